// ---- rtl/nhc_unit.sv ----
// host command unit of the coaxial network adapter
`timescale 1ns/1ps
// Behaviour
// - command 000 clears interface parity error
// - command 001 cancels transmit, available within 500ms
// - after cancel, next token sets transmitter available
// - command 002 cancels receive, inhibited on token
// - command 0nn3 loads processor page register
// - command 0nn4 loads tx page, clears, transmits
// - transmit end sets available, acknowledge first
// - bad buffer parity aborts packet, sets error
// - command 0nn5 loads rx page, enables reception
// - inhibited set after good accepted packet
// - command 006 clears power-on flag
// - reset sets available and inhibited
// - command 007 clears reconfiguration flag
// - address load sets address, data mode
// - transmit page layout: destination, count, data
// - receiver stores source, destination, count, data
// - unicast waits for free remote buffer
// - receive page offset one selects broadcast
// - counts below three send 253 bytes
// - buffer address increments, wraps within page
// - status byte layout, device bit reads one
module nhc_unit #(
	parameter int unsigned TX_CANCEL_CYCLES = nhc_pkg::TX_CANCEL_CYC,
	parameter int unsigned RX_CANCEL_CYCLES = nhc_pkg::RX_CANCEL_CYC,
	parameter int unsigned AXI_AW = 4
) (
	// clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	// host i/o bus
	input wire logic [7:0] host_bus_i,
	input wire logic host_parity_i,
	input wire logic general_command_strobe_i,
	input wire logic address_load_strobe_i,
	input wire logic buffer_write_strobe_i,
	input wire logic status_mode_strobe_i,
	input wire logic data_mode_strobe_i,
	input wire logic input_strobe_i,
	output logic [7:0] host_rd_data_o,
	output logic host_rd_parity_o,
	output logic host_rd_valid_o,
	// network events
	input wire logic invite_token_i,
	input wire logic reconfig_i,
	input wire logic power_restored_i,
	// transmitter engine
	output logic tx_start_o,
	output logic tx_cancel_o,
	input wire logic tx_rd_en_i,
	input wire logic [7:0] tx_rd_off_i,
	output logic [7:0] tx_rd_data_o,
	output logic tx_rd_valid_o,
	output logic tx_abort_o,
	output logic tx_broadcast_o,
	output logic [7:0] tx_first_data_o,
	input wire logic tx_ack_i,
	input wire logic tx_done_i,
	// receiver engine
	output logic rx_enabled_o,
	output logic rx_cancel_o,
	output logic rx_accept_bcast_o,
	input wire logic rx_wr_en_i,
	input wire logic [7:0] rx_wr_off_i,
	input wire logic [7:0] rx_wr_data_i,
	input wire logic rx_pkt_good_i,
	// axi4-lite slave
	input wire logic [AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import nhc_pkg::*;

	typedef struct packed {
		nhc_tx_st_t tx_st; // transmitter state, idle means available
		nhc_rx_st_t rx_st; // receiver state, idle means inhibited
		logic tx_acknowledged; // acknowledge seen
		logic tx_parity_error; // transmit parity error
		logic reconfig_seen; // reconfiguration seen
		logic por; // power returned
		logic iface_parity_error; // host bus parity error
		logic [1:0] proc_pg; // host page
		logic [1:0] tx_pg; // transmitter page
		logic [1:0] rx_pg; // receiver page
		logic [7:0] addr; // host byte address within page
		logic data_mode; // input reads buffer, else status
		logic [3:0] bcast_ok; // per page: offset one held zero
		logic rd_pend; // host read waiting one cycle
		logic rd_stat; // that read is a status read
		logic [7:0] host_data; // host read data
		logic host_par; // host read parity
		logic host_vld; // host read strobe
		logic tx_rd_pend; // transmitter read waiting
		logic [7:0] tx_rd_off; // offset of that read
		logic [7:0] tx_data; // transmitter read data
		logic tx_vld; // transmitter read strobe
		logic tx_bcast; // destination is broadcast
		logic [7:0] tx_first; // first data offset
		logic tx_abort; // abort pulse
		logic tx_start; // start pulse
		logic tx_cancel; // cancel pulse
		logic rx_cancel; // receive cancel pulse
		logic par_en; // host bus parity checking on
		logic aw_full; // write address held
		logic [AXI_AW-1:0] aw_addr; // held write address
		logic w_full; // write data held
		logic [7:0] w_lo; // held low byte
		logic w_stb0; // held lane zero strobe
		logic bvalid; // write response pending
		logic [1:0] bresp; // write response code
		logic rvalid; // read response pending
		logic [15:0] rdata; // read data
		logic [1:0] rresp; // read response code
	} nhc_state_t;

	localparam nhc_state_t ST_RST = '{tx_st: TX_IDLE, rx_st: RX_IDLE,
		por: RST_POR, par_en: RST_PAR_EN, default: '0};

	nhc_state_t s_q;
	nhc_state_t s_d;
	logic [BUF_DW-1:0] a_rdata; // host word from buffer
	logic [BUF_DW-1:0] b_rdata; // transmitter word from buffer
	logic gen, adl, wr, rd; // strobes after priority
	logic plain_cmd, pg_cmd; // command shape checks
	logic bus_bad; // host bus parity wrong on a taken strobe
	logic tx_expire, rx_expire; // cancel deadlines reached
	logic aw_take, w_take, ar_take; // bus handshakes

	// status byte assembly
	function automatic logic [7:0] status_of(input nhc_state_t s);
		logic [7:0] v;
		v = '0;
		v[ST_TA] = (s.tx_st == TX_IDLE);
		v[ST_TMA] = s.tx_acknowledged;
		v[ST_RECONFIG_SEEN] = s.reconfig_seen;
		v[ST_TPE] = s.tx_parity_error;
		v[ST_POR] = s.por;
		v[ST_DEV] = 1'b1;
		v[ST_IPE] = s.iface_parity_error;
		v[ST_RI] = (s.rx_st == RX_IDLE);
		return v;
	endfunction : status_of

	// known register offsets
	function automatic logic reg_known(input logic [AXI_AW-1:0] a);
		return (a == REG_STATUS) || (a == REG_PAGES) || (a == REG_CTRL);
	endfunction : reg_known

	// strobe priority and command shape
	assign gen = general_command_strobe_i;
	assign adl = address_load_strobe_i && !gen;
	assign wr = buffer_write_strobe_i && !gen && !address_load_strobe_i;
	assign rd = input_strobe_i && !gen && !address_load_strobe_i
		&& !buffer_write_strobe_i;
	assign plain_cmd = (host_bus_i[7:3] == 5'h00);
	assign pg_cmd = (host_bus_i[7:5] == 3'h0);
	assign bus_bad = s_q.par_en && (gen || adl || wr)
		&& !odd_ok(host_bus_i, host_parity_i);
	// bus handshakes, frozen with the enable
	assign s_axi_awready = ce_i && !s_q.aw_full && !s_q.bvalid;
	assign s_axi_wready = ce_i && !s_q.w_full && !s_q.bvalid;
	assign s_axi_arready = ce_i && !s_q.rvalid;
	assign aw_take = s_axi_awvalid && s_axi_awready;
	assign w_take = s_axi_wvalid && s_axi_wready;
	assign ar_take = s_axi_arvalid && s_axi_arready;

	// next-state logic
	always_comb begin
		s_d = s_q;
		s_d.host_vld = 1'b0;
		s_d.tx_vld = 1'b0;
		s_d.tx_abort = 1'b0;
		s_d.tx_start = 1'b0;
		s_d.tx_cancel = 1'b0;
		s_d.rx_cancel = 1'b0;
		s_d.rd_pend = 1'b0;
		s_d.tx_rd_pend = 1'b0;
		// general commands
		if (gen) begin
			case (host_bus_i[2:0])
				CMD_CLR_IPE: if (plain_cmd) s_d.iface_parity_error = 1'b0;
				CMD_TX_OFF: if (plain_cmd && s_q.tx_st != TX_IDLE) begin
					s_d.tx_st = TX_CANCEL;
					s_d.tx_cancel = 1'b1;
				end
				CMD_RX_OFF: if (plain_cmd && s_q.rx_st != RX_IDLE) begin
					s_d.rx_st = RX_CANCEL;
					s_d.rx_cancel = 1'b1;
				end
				CMD_PROC_PG: if (pg_cmd) s_d.proc_pg = host_bus_i[4:3];
				CMD_TX_EN: if (pg_cmd) begin
					s_d.tx_pg = host_bus_i[4:3];
					s_d.tx_st = TX_BUSY;
					s_d.tx_acknowledged = 1'b0;
					s_d.tx_parity_error = 1'b0;
					s_d.tx_start = 1'b1;
				end
				CMD_RX_EN: if (pg_cmd) begin
					s_d.rx_pg = host_bus_i[4:3];
					s_d.rx_st = RX_ARMED;
				end
				CMD_CLR_POR: if (plain_cmd) s_d.por = 1'b0;
				CMD_CLR_RECONFIG_SEEN: if (plain_cmd) s_d.reconfig_seen = 1'b0;
				default: s_d = s_q;
			endcase
		end
		// address load keeps all pages
		if (adl) begin
			s_d.addr = host_bus_i;
			s_d.data_mode = 1'b1;
		end
		// mode strobes
		if (status_mode_strobe_i) begin
			s_d.data_mode = 1'b0;
		end
		if (data_mode_strobe_i) begin
			s_d.data_mode = 1'b1;
		end
		// host write, offset one remembers broadcast choice
		if (wr) begin
			s_d.addr = s_q.addr + 8'h01;
			if (s_q.addr == OFF_DEST) begin
				s_d.bcast_ok[s_q.proc_pg] = (host_bus_i == 8'h00);
			end
		end
		// host input, buffer word or status
		if (rd) begin
			s_d.rd_pend = 1'b1;
			s_d.rd_stat = !s_q.data_mode;
			if (s_q.data_mode) begin
				s_d.addr = s_q.addr + 8'h01;
			end
		end
		if (s_q.rd_pend) begin
			s_d.host_vld = 1'b1;
			if (s_q.rd_stat) begin
				s_d.host_data = status_of(s_q);
				s_d.host_par = ~^status_of(s_q);
			end else begin
				s_d.host_data = a_rdata[7:0];
				s_d.host_par = a_rdata[8];
			end
		end
		// transmitter reads, layout snoop and parity check
		if (tx_rd_en_i) begin
			s_d.tx_rd_pend = 1'b1;
			s_d.tx_rd_off = tx_rd_off_i;
		end
		if (s_q.tx_rd_pend) begin
			s_d.tx_vld = 1'b1;
			s_d.tx_data = b_rdata[7:0];
			if (s_q.tx_rd_off == OFF_DEST) begin
				s_d.tx_bcast = (b_rdata[7:0] == 8'h00);
			end
			if (s_q.tx_rd_off == OFF_COUNT) begin
				s_d.tx_first = first_data(b_rdata[7:0]);
			end
			if (s_q.tx_st == TX_BUSY && !odd_ok(b_rdata[7:0], b_rdata[8])) begin
				s_d.tx_parity_error = 1'b1;
				s_d.tx_abort = 1'b1;
			end
		end
		// transmitter events; acknowledge lands no later than done
		if (s_q.tx_st == TX_BUSY) begin
			if (tx_ack_i) begin
				s_d.tx_acknowledged = 1'b1;
			end
			if (tx_done_i) begin
				s_d.tx_st = TX_IDLE;
			end
		end
		// cancel ends on the next token or at the deadline
		if (s_q.tx_st == TX_CANCEL && (invite_token_i || tx_expire)) begin
			s_d.tx_st = TX_IDLE;
		end
		if (s_q.rx_st == RX_CANCEL && (invite_token_i || rx_expire)) begin
			s_d.rx_st = RX_IDLE;
		end
		if (s_q.rx_st == RX_ARMED && rx_pkt_good_i) begin
			s_d.rx_st = RX_IDLE;
		end
		// flags set by events win over clears
		if (bus_bad) begin
			s_d.iface_parity_error = 1'b1;
		end
		if (reconfig_i) begin
			s_d.reconfig_seen = 1'b1;
		end
		if (power_restored_i) begin
			s_d.por = 1'b1;
		end
		// lite bus write side
		if (aw_take) begin
			s_d.aw_full = 1'b1;
			s_d.aw_addr = s_axi_awaddr;
		end
		if (w_take) begin
			s_d.w_full = 1'b1;
			s_d.w_lo = s_axi_wdata[7:0];
			s_d.w_stb0 = s_axi_wstrb[0];
		end
		if (s_q.aw_full && s_q.w_full && !s_q.bvalid) begin
			s_d.aw_full = 1'b0;
			s_d.w_full = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = reg_known(s_q.aw_addr) ? RESP_OKAY : RESP_SLVERR;
			if (s_q.aw_addr == REG_CTRL && s_q.w_stb0) begin
				s_d.par_en = s_q.w_lo[CTRL_PAR_BIT];
			end
		end
		if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid = 1'b0;
		end
		// lite bus read side
		if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid = 1'b0;
		end
		if (ar_take) begin
			s_d.rvalid = 1'b1;
			s_d.rdata = '0;
			s_d.rresp = reg_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			case (s_axi_araddr)
				REG_STATUS: s_d.rdata[7:0] = status_of(s_q);
				REG_PAGES: begin
					s_d.rdata[PG_PROC_LSB +: 2] = s_q.proc_pg;
					s_d.rdata[PG_TX_LSB +: 2] = s_q.tx_pg;
					s_d.rdata[PG_RX_LSB +: 2] = s_q.rx_pg;
					s_d.rdata[PG_ADDR_LSB +: 8] = s_q.addr;
				end
				REG_CTRL: s_d.rdata[CTRL_PAR_BIT] = s_q.par_en;
				default: s_d.rdata = '0;
			endcase
		end
	end

	// state register; reset makes transmitter available, receiver inhibited
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_q <= ST_RST;
		end else if (ce_i) begin
			s_q <= s_d;
		end
	end

	// packet buffer; receiver writes only while enabled
	nhc_buffer u_buf (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.ce_i(ce_i),
		.a_we_i(ce_i && wr),
		.a_addr_i({s_q.proc_pg, s_q.addr}),
		.a_wdata_i({host_parity_i, host_bus_i}),
		.a_rdata_o(a_rdata),
		.b_addr_i({s_q.tx_pg, tx_rd_off_i}),
		.b_rdata_o(b_rdata),
		.c_we_i(ce_i && rx_wr_en_i && s_q.rx_st == RX_ARMED),
		.c_addr_i({s_q.rx_pg, rx_wr_off_i}),
		.c_wdata_i({~^rx_wr_data_i, rx_wr_data_i})
	);

	// deadline after a transmit cancel
	nhc_timer #(.CYCLES(TX_CANCEL_CYCLES)) u_tx_tmr (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.ce_i(ce_i),
		.run_i(s_q.tx_st == TX_CANCEL),
		.expire_o(tx_expire)
	);

	// deadline after a receive cancel
	nhc_timer #(.CYCLES(RX_CANCEL_CYCLES)) u_rx_tmr (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.ce_i(ce_i),
		.run_i(s_q.rx_st == RX_CANCEL),
		.expire_o(rx_expire)
	);

	// outputs
	assign host_rd_data_o = s_q.host_data;
	assign host_rd_parity_o = s_q.host_par;
	assign host_rd_valid_o = s_q.host_vld;
	assign tx_start_o = s_q.tx_start;
	assign tx_cancel_o = s_q.tx_cancel;
	assign tx_rd_data_o = s_q.tx_data;
	assign tx_rd_valid_o = s_q.tx_vld;
	assign tx_abort_o = s_q.tx_abort;
	assign tx_broadcast_o = s_q.tx_bcast;
	assign tx_first_data_o = s_q.tx_first;
	assign rx_enabled_o = (s_q.rx_st == RX_ARMED);
	assign rx_cancel_o = s_q.rx_cancel;
	assign rx_accept_bcast_o = s_q.bcast_ok[s_q.rx_pg];
	assign s_axi_bresp = s_q.bresp;
	assign s_axi_bvalid = s_q.bvalid;
	assign s_axi_rdata = {16'h0000, s_q.rdata};
	assign s_axi_rresp = s_q.rresp;
	assign s_axi_rvalid = s_q.rvalid;

	// checks
	a_ipe_clear: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		ce_i && gen && host_bus_i == 8'h00 && !bus_bad |=> !s_q.iface_parity_error)
		else $error("interface parity flag not cleared");
	a_tx_enable: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		ce_i && gen && pg_cmd && host_bus_i[2:0] == CMD_TX_EN
		|=> s_q.tx_st == TX_BUSY && tx_start_o
		&& s_q.tx_pg == $past(host_bus_i[4:3]))
		else $error("transmit enable not applied");
	a_cancel_tok: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		ce_i && s_q.tx_st == TX_CANCEL && invite_token_i
		|=> s_q.tx_st == TX_IDLE)
		else $error("token did not end transmit cancel");
	a_rx_enable: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		ce_i && gen && pg_cmd && host_bus_i[2:0] == CMD_RX_EN
		|=> rx_enabled_o && s_q.rx_st != RX_IDLE)
		else $error("receive enable not applied");
	a_ri_good: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		ce_i && rx_enabled_o && rx_pkt_good_i |=> s_q.rx_st == RX_IDLE)
		else $error("good packet did not inhibit receiver");
	a_addr_incr: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		ce_i && wr |=> s_q.addr == $past(s_q.addr) + 8'h01)
		else $error("buffer address not advanced");
	a_ignore_bad: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		ce_i && gen && !pg_cmd && !status_mode_strobe_i
		&& !data_mode_strobe_i && !rd && !tx_rd_en_i
		|=> $stable(s_q.proc_pg) && $stable(s_q.tx_pg)
		&& $stable(s_q.rx_pg) && $stable(s_q.addr))
		else $error("undefined command changed state");
	a_tpe_abort: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		tx_abort_o |-> s_q.tx_parity_error && tx_rd_valid_o)
		else $error("abort without parity error");
	a_host_read: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		ce_i && rd && !s_q.data_mode ##1 ce_i |=> host_rd_valid_o
		&& host_rd_data_o[ST_DEV])
		else $error("status read missing or malformed");
endmodule : nhc_unit

// ---- rtl/nhc_pkg.sv ----
// shared constants and types of the adapter host command unit
package nhc_pkg;
	// clock rate and the two cancel deadlines
	localparam int unsigned CLK_HZ = 25_000_000;
	localparam int unsigned TX_CANCEL_MS = 500;
	localparam int unsigned RX_CANCEL_MS = 400;
	// longest times, so the cycle counts round down
	localparam int unsigned TX_CANCEL_CYC = TX_CANCEL_MS * (CLK_HZ / 1000);
	localparam int unsigned RX_CANCEL_CYC = RX_CANCEL_MS * (CLK_HZ / 1000);
	localparam int unsigned TMR_W = 24;
	// buffer geometry: four pages of 256 bytes, parity kept per byte
	localparam int unsigned BUF_BYTES = 1024;
	localparam int unsigned BUF_AW = 10;
	localparam int unsigned BUF_DW = 9;
	// general command codes in the low three bits of the bus
	localparam logic [2:0] CMD_CLR_IPE = 3'h0;
	localparam logic [2:0] CMD_TX_OFF = 3'h1;
	localparam logic [2:0] CMD_RX_OFF = 3'h2;
	localparam logic [2:0] CMD_PROC_PG = 3'h3;
	localparam logic [2:0] CMD_TX_EN = 3'h4;
	localparam logic [2:0] CMD_RX_EN = 3'h5;
	localparam logic [2:0] CMD_CLR_POR = 3'h6;
	localparam logic [2:0] CMD_CLR_RECONFIG_SEEN = 3'h7;
	// status byte bit positions
	localparam int unsigned ST_TA = 0;
	localparam int unsigned ST_TMA = 1;
	localparam int unsigned ST_RECONFIG_SEEN = 2;
	localparam int unsigned ST_TPE = 3;
	localparam int unsigned ST_POR = 4;
	localparam int unsigned ST_DEV = 5;
	localparam int unsigned ST_IPE = 6;
	localparam int unsigned ST_RI = 7;
	// packet layout offsets within a page
	localparam logic [7:0] OFF_DEST = 8'h01;
	localparam logic [7:0] OFF_COUNT = 8'h02;
	localparam logic [7:0] MIN_COUNT = 8'h03;
	// register byte offsets on the lite bus
	localparam logic [3:0] REG_STATUS = 4'h0;
	localparam logic [3:0] REG_PAGES = 4'h4;
	localparam logic [3:0] REG_CTRL = 4'h8;
	// field positions in the pages and control registers
	localparam int unsigned PG_PROC_LSB = 0;
	localparam int unsigned PG_TX_LSB = 2;
	localparam int unsigned PG_RX_LSB = 4;
	localparam int unsigned PG_ADDR_LSB = 8;
	localparam int unsigned CTRL_PAR_BIT = 0;
	// values after reset
	localparam logic RST_POR = 1'b1;
	localparam logic RST_PAR_EN = 1'b1;
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// one-hot state codes
	typedef enum logic [2:0] {
		TX_IDLE = 3'h1,
		TX_BUSY = 3'h2,
		TX_CANCEL = 3'h4
	} nhc_tx_st_t;
	typedef enum logic [2:0] {
		RX_IDLE = 3'h1,
		RX_ARMED = 3'h2,
		RX_CANCEL = 3'h4
	} nhc_rx_st_t;
	// odd parity over data and parity bit
	function automatic logic odd_ok(input logic [7:0] d, input logic p);
		return ^{p, d};
	endfunction : odd_ok
	// first data offset for a length count; short counts act as three
	function automatic logic [7:0] first_data(input logic [7:0] count);
		return (count < MIN_COUNT) ? MIN_COUNT : count;
	endfunction : first_data
endpackage : nhc_pkg

// ---- rtl/nhc_timer.sv ----
// run-length timer that flags when a run reaches its cycle count
`timescale 1ns/1ps
module nhc_timer #(
	parameter int unsigned CYCLES = 16
) (
	// clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	// run control
	input wire logic run_i,
	output logic expire_o
);
	import nhc_pkg::*;
	typedef struct packed {
		logic [TMR_W-1:0] cnt; // cycles spent in the run
	} nhc_tmr_t;
	localparam logic [TMR_W-1:0] LAST = TMR_W'(CYCLES - 1);
	nhc_tmr_t s_q;
	nhc_tmr_t s_d;
	// count while running, restart when the run ends
	always_comb begin
		s_d = s_q;
		if (!run_i) begin
			s_d.cnt = '0;
		end else if (s_q.cnt != LAST) begin
			s_d.cnt = s_q.cnt + 1'b1;
		end
	end
	// high in the last cycle of a full run
	assign expire_o = run_i && (s_q.cnt == LAST);
	// state register
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_q <= '0;
		end else if (ce_i) begin
			s_q <= s_d;
		end
	end
endmodule : nhc_timer

// ---- rtl/nhc_buffer.sv ----
// packet buffer: host port, transmitter read port, receiver write port
`timescale 1ns/1ps
module nhc_buffer #(
	parameter int unsigned DEPTH = nhc_pkg::BUF_BYTES,
	parameter int unsigned AW = nhc_pkg::BUF_AW,
	parameter int unsigned DW = nhc_pkg::BUF_DW
) (
	// clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	// host port
	input wire logic a_we_i,
	input wire logic [AW-1:0] a_addr_i,
	input wire logic [DW-1:0] a_wdata_i,
	output logic [DW-1:0] a_rdata_o,
	// transmitter port
	input wire logic [AW-1:0] b_addr_i,
	output logic [DW-1:0] b_rdata_o,
	// receiver port
	input wire logic c_we_i,
	input wire logic [AW-1:0] c_addr_i,
	input wire logic [DW-1:0] c_wdata_i
);
	import nhc_pkg::*;
	typedef struct packed {
		logic [DW-1:0] a; // host read word
		logic [DW-1:0] b; // transmitter read word
	} nhc_buf_t;
	logic [DW-1:0] mem [DEPTH]; // contents undefined after power-up
	nhc_buf_t s_q;
	nhc_buf_t s_d;
	// both read ports sample every enabled cycle
	always_comb begin
		s_d.a = mem[a_addr_i];
		s_d.b = mem[b_addr_i];
	end
	// writes; the receiver wins a same-word collision
	always_ff @(posedge clk_i) begin
		if (ce_i && a_we_i) begin
			mem[a_addr_i] <= a_wdata_i;
		end
		if (ce_i && c_we_i) begin
			mem[c_addr_i] <= c_wdata_i;
		end
	end
	// read registers
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_q <= '0;
		end else if (ce_i) begin
			s_q <= s_d;
		end
	end
	assign a_rdata_o = s_q.a;
	assign b_rdata_o = s_q.b;
endmodule : nhc_buffer

// ---- verif/nhc_host_model.sv ----
// host processor model driving the adapter i/o bus strobes
`timescale 1ns/1ps
module nhc_host_model (
	// clock
	input wire logic clk_i,
	// i/o bus: strobes are gen, addr, write, status, data, input
	output logic [7:0] bus_o,
	output logic par_o,
	output logic [5:0] stb_o
);
	logic bad = 1'b0; // set by the bench to send wrong parity
	// idle bus after time zero
	initial begin
		bus_o = 8'h5A;
		par_o = 1'b0;
		stb_o = 6'h00;
	end
	// one strobe for one cycle, odd parity on the bus
	task automatic op(input int s, input logic [7:0] d);
		@(posedge clk_i);
		bus_o <= d;
		par_o <= ~^d ^ bad;
		stb_o <= 6'h01 << s;
		@(posedge clk_i);
		stb_o <= 6'h00;
		// released bus must not keep the old value
		bus_o <= ~d;
	endtask : op
endmodule : nhc_host_model

// ---- verif/nhc_unit_tb_top.sv ----
// self-checking bench of the host command unit
`timescale 1ns/1ps
module nhc_unit_tb_top;
	import nhc_pkg::*;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [6:0] ev = 7'h00; // invite,reconfig_seen,power,ack,done,good,txrd
	logic [3:0] awaddr = 4'h0, araddr = 4'h0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = 32'h0, rdat;
	logic [7:0] hb, rd, txd, r[3];
	logic hp, rdv, awr, wr, bv, arr, rv;
	logic [5:0] hs;
	logic rdp, tbc, bc; // read parity, tx broadcast, rx broadcast ok
	logic [7:0] tf; // tx first data offset
	logic [7:0] txoff = 8'h00; // tx read offset
	logic [3:0] strb = 4'h1; // lite write strobes
	logic ce = 1'b1; // clock enable
	logic [1:0] br, rr;
	logic [7:0] q[$];
	int fail_count = 0, total_checks = 0, cyc = 0;
	nhc_host_model m (.clk_i(clk_i), .bus_o(hb), .par_o(hp), .stb_o(hs));
	nhc_unit #(.TX_CANCEL_CYCLES(20), .RX_CANCEL_CYCLES(16)) dut (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce),
		.host_bus_i(hb), .host_parity_i(hp),
		.general_command_strobe_i(hs[0]), .address_load_strobe_i(hs[1]),
		.buffer_write_strobe_i(hs[2]), .status_mode_strobe_i(hs[3]),
		.data_mode_strobe_i(hs[4]), .input_strobe_i(hs[5]),
		.host_rd_data_o(rd), .host_rd_parity_o(rdp), .host_rd_valid_o(rdv),
		.invite_token_i(ev[0]), .reconfig_i(ev[1]),
		.power_restored_i(ev[2]), .tx_start_o(), .tx_cancel_o(),
		.tx_rd_en_i(ev[6]), .tx_rd_off_i(txoff), .tx_rd_data_o(txd),
		.tx_rd_valid_o(), .tx_abort_o(), .tx_broadcast_o(tbc),
		.tx_first_data_o(tf), .tx_ack_i(ev[3]), .tx_done_i(ev[4]),
		.rx_enabled_o(), .rx_cancel_o(), .rx_accept_bcast_o(bc),
		.rx_wr_en_i(1'b0), .rx_wr_off_i(8'h00), .rx_wr_data_i(8'h00),
		.rx_pkt_good_i(ev[5]), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awr), .s_axi_wdata(wdata),
		.s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wr),
		.s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr),
		.s_axi_rvalid(rv), .s_axi_rready(rready));
	// clock, 40 ns period
	initial begin
		forever #20 clk_i = ~clk_i;
	end
	task automatic chk(input string n, input logic [7:0] s, e);
		total_checks++;
		if (s !== e) begin
			fail_count++;
			$display("wrong value %s exp %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : final_report
	// expected status byte noted, then status mode and input
	task automatic st(input logic [7:0] e);
		q.push_back(e);
		m.op(3, 8'h00);
		m.op(5, 8'h00);
		repeat (4) @(posedge clk_i);
	endtask : st
	task automatic pu(input logic [6:0] b);
		@(posedge clk_i);
		ev <= b;
		@(posedge clk_i);
		ev <= 7'h00;
	endtask : pu
	// lite read: hold arvalid to arready, rready to rvalid
	task automatic axrd(input logic [3:0] a);
		@(posedge clk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk_i); while (arr !== 1'b1);
		arvalid <= 1'b0;
		while (rv !== 1'b1) @(posedge clk_i);
		rready <= 1'b0;
	endtask : axrd
	// lite write: each of aw and w held until its own ready
	task automatic axwr(input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] s);
		logic pa, pw;
		pa = 1'b1;
		pw = 1'b1;
		@(posedge clk_i);
		strb <= s;
		{awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
		do begin
			@(posedge clk_i);
			if (pa && awr === 1'b1) begin
				pa = 1'b0;
				awvalid <= 1'b0;
			end
			if (pw && wr === 1'b1) begin
				pw = 1'b0;
				wvalid <= 1'b0;
			end
		end while (pa || pw);
		while (bv !== 1'b1) @(posedge clk_i);
		bready <= 1'b0;
	endtask : axwr
	// monitor takes the oldest note at each read answer
	always @(posedge clk_i) begin
		if (rdv === 1'b1) begin
			chk("host read", rd, q.pop_front());
			chk("host parity", {7'h00, ^{rdp, rd}}, 8'h01);
		end
	end
	// hang guard
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			final_report();
		end
	end
	initial begin
		void'($urandom(32'hA217));
		repeat (4) @(posedge clk_i);
		rst_b_i <= 1'b1;
		st(8'hB1);
		pu(7'h06);
		st(8'hB5);
		ce <= 1'b0;
		m.op(0, 8'h06);
		ce <= 1'b1;
		st(8'hB5);
		m.op(0, 8'h06);
		st(8'hA5);
		m.op(0, 8'h07);
		m.bad = 1'b1;
		m.op(0, 8'h08);
		m.bad = 1'b0;
		st(8'hE1);
		m.op(0, 8'h00);
		st(8'hA1);
		m.op(0, 8'h13);
		m.op(0, 8'h2B);
		m.op(1, 8'hFE);
		for (int i = 0; i < 3; i++) begin
			r[i] = 8'($urandom);
			m.op(2, r[i]);
		end
		m.op(1, OFF_DEST);
		m.op(2, 8'h00);
		m.op(2, 8'h01);
		m.op(1, 8'hFE);
		for (int i = 0; i < 3; i++) begin
			q.push_back(r[i]);
			m.op(5, 8'h00);
		end
		m.op(0, 8'h14);
		st(8'hA0);
		pu(7'h40);
		repeat (3) @(posedge clk_i);
		chk("tx byte", txd, r[2]);
		txoff <= OFF_DEST;
		pu(7'h40);
		repeat (3) @(posedge clk_i);
		chk("tx bcast", {7'h00, tbc}, 8'h01);
		txoff <= OFF_COUNT;
		pu(7'h40);
		repeat (3) @(posedge clk_i);
		chk("tx first", tf, MIN_COUNT);
		pu(7'h08);
		pu(7'h10);
		st(8'hA3);
		m.op(0, 8'h0C);
		m.op(0, 8'h01);
		st(8'hA0);
		pu(7'h01);
		st(8'hA1);
		m.op(0, 8'h0C);
		m.op(0, 8'h01);
		repeat (24) @(posedge clk_i);
		st(8'hA1);
		m.op(0, 8'h15);
		m.op(0, 8'h02);
		st(8'h21);
		chk("rx bcast", {7'h00, bc}, 8'h01);
		pu(7'h01);
		st(8'hA1);
		m.op(0, 8'h05);
		st(8'h21);
		chk("rx no bcast", {7'h00, bc}, 8'h00);
		pu(7'h20);
		st(8'hA1);
		axrd(4'h0);
		chk("lite status", rdat[7:0], 8'hA1);
		axrd(4'h4);
		chk("lite pages", rdat[7:0], 8'h06);
		chk("lite addr", rdat[15:8], 8'h01);
		axwr(4'h8, 32'h0, 4'h0);
		axrd(4'h8);
		chk("lite ctrl kept", rdat[7:0], {7'h00, RST_PAR_EN});
		axwr(4'h8, 32'h0, 4'h1);
		chk("lite wresp", {6'h00, br}, {6'h00, RESP_OKAY});
		axrd(4'h8);
		chk("lite ctrl", rdat[7:0], 8'h00);
		axrd(4'hC);
		chk("lite unmapped", {6'h00, rr}, {6'h00, RESP_SLVERR});
		final_report();
	end
endmodule : nhc_unit_tb_top
